// [rtl/cws_defs.svh]
// offsets, field positions, memory layout and timing counts of the write sequencer
`ifndef CWS_DEFS_SVH
`define CWS_DEFS_SVH

// ==========================================
// device register offsets
`define CWS_ENABLE_OFS 8'h6c
`define CWS_PROG_OFS 8'h6d
`define CWS_STEPDAT_OFS 8'h6e
`define CWS_LAUNCH_OFS 8'h6f
`define CWS_PROGRESS_OFS 8'h70
`define CWS_IRQ_STATUS_OFS 8'h7f
`define CWS_SOFT_RESET_OFS 8'h00
// ==========================================
// field positions
`define CWS_ENA_BIT 8
`define CWS_LAUNCH_BIT 8
`define CWS_CANCEL_BIT 9
`define CWS_BUSY_BIT 0
`define CWS_PTR_LSB 4
`define CWS_LAST_BIT 14
`define CWS_DONE_IRQ_BIT 0
// ==========================================
// memory layout
`define CWS_RAM_TOP 6'h1f
`define CWS_ROM_TOP 6'h30
`define CWS_MEM_WORDS 49
// ==========================================
// timing: 62.5 us unit at 25 MHz
`define CWS_UNIT_NS 62500
`define CWS_CLK_NS 40
`define CWS_UNIT_CYC (`CWS_UNIT_NS / `CWS_CLK_NS)
// ==========================================
// host-side register offsets
`define CWS_H_CMD_OFS 4'h0
`define CWS_H_STAT_OFS 4'h1
`define CWS_H_IRQ_STAT_OFS 4'h2
`define CWS_H_IRQ_CLR_OFS 4'h3
`define CWS_H_IRQ_EN_OFS 4'h4
`define CWS_H_RDATA_OFS 4'h5
`define CWS_H_ADDR_OFS 4'h6
`define CWS_H_WDATA_OFS 4'h7
// host command codes
`define CWS_H_CMD_WRITE 2'h1
`define CWS_H_CMD_READ 2'h2

`endif

// [rtl/cws_pkg.sv]
// types shared by both ends of the write sequencer link
package cws_pkg;
    typedef logic [7:0] cws_addr_t;
    typedef logic [15:0] cws_word_t;
    typedef enum logic [3:0] {
        CWS_IDLE = 4'h1,
        CWS_FETCH = 4'h2,
        CWS_APPLY = 4'h4,
        CWS_WAIT = 4'h8
    } cws_state_t;
    typedef enum logic [2:0] {
        CWS_H_IDLE = 3'h1,
        CWS_H_READ = 3'h2,
        CWS_H_WROTE = 3'h4
    } cws_hstate_t;
endpackage

// [rtl/cws_link_if.sv]
// register access link between the host controller and the sequencer device
interface cws_link_if;
    import cws_pkg::*;
    logic wr;
    logic rd;
    cws_addr_t addr;
    cws_word_t wdata;
    cws_word_t rdata;
    logic rvalid;
    logic irq;
    modport host (output wr, output rd, output addr, output wdata,
        input rdata, input rvalid, input irq);
    modport dev (input wr, input rd, input addr, input wdata,
        output rdata, output rvalid, output irq);
endinterface

// [rtl/cws_device.sv]
// control write sequencer device end with its control register file
// How it works
// - steps run upward from index until marker
// - last step halts and raises done flag
// - runs only with system clock enabled
// - host supplies master clock and enables
// - enable bit 8 of 0x6c gates sequencer
// - launch bit starts at first step index
// - launch bit self-clears at sequence end
// - first step six bits, reserved above 48
// - cancel bit stops walk at once
// - running flag bit 0 of 0x70
// - only sequencer registers reachable while running
// - step pointer shows last accessed step
// - done flag marks sequencer not busy
// - host prefers built-in start and stop sequences
// - step writes only its selected bit field
// - step lasts unit times two-power-code plus eight
// - last marker stops after its step
//
// Added by the designer: the plain strobed port.
`include "cws_defs.svh"

module cws_device (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // system clock enable from the clocking block
    input wire logic system_clock_enable_in,
    // register link
    cws_link_if.dev link,
    // status seen by the chip
    output logic seq_running_out,
    output logic [5:0] seq_step_pointer_out
);
    import cws_pkg::*;

    localparam int UNIT = `CWS_UNIT_CYC;

    // ==========================================
    // storage
    cws_word_t ctrl_mem [0:255];
    logic [27:0] step_mem [0:`CWS_MEM_WORDS-1];
    cws_state_t state_r;
    logic [4:0] write_index_r;
    logic [14:0] prog_r;
    logic [14:0] stepdat_r;
    logic seq_clock_enable_r;
    logic seq_launch_r;
    logic [5:0] seq_first_step_r;
    logic [5:0] seq_step_pointer_r;
    logic seq_done_irq_flag_r;
    logic [27:0] step_r;
    logic [25:0] wait_cnt_r;
    cws_word_t rdata_r;
    logic rvalid_r;

    // ==========================================
    // decoding
    function automatic logic is_seq_reg(input cws_addr_t a);
        return (a >= `CWS_ENABLE_OFS && a <= `CWS_PROGRESS_OFS) ||
            a == `CWS_IRQ_STATUS_OFS || a == `CWS_SOFT_RESET_OFS;
    endfunction

    wire logic running = (state_r != CWS_IDLE);
    wire logic seq_clk_on = seq_clock_enable_r && system_clock_enable_in;
    wire logic host_ok = !running || is_seq_reg(link.addr);
    wire logic host_wr = link.wr && host_ok;
    wire logic wr_launch = host_wr && link.addr == `CWS_LAUNCH_OFS;
    wire logic start_req = wr_launch && link.wdata[`CWS_LAUNCH_BIT] &&
        !link.wdata[`CWS_CANCEL_BIT] && !running &&
        link.wdata[5:0] <= `CWS_ROM_TOP;
    wire logic cancel_req = wr_launch && link.wdata[`CWS_CANCEL_BIT];
    wire logic [7:0] s_addr = step_r[7:0];
    wire logic [3:0] s_off = step_r[11:8];
    wire logic [2:0] s_cnt = step_r[14:12];
    wire logic [7:0] s_data = step_r[22:15];
    wire logic [3:0] s_wait = step_r[26:23];
    wire logic s_last = step_r[27];
    wire cws_word_t fmask = 16'(((17'h1 << (s_cnt + 4'h1)) - 17'h1) << s_off);
    wire cws_word_t fdata = 16'({8'h00, s_data} << s_off) & fmask;
    wire logic [25:0] step_cyc = 26'((26'h1 << s_wait) + 26'h8) * 26'(UNIT);
    wire logic wait_done = (wait_cnt_r == 26'h0000001);
    wire logic seq_end = state_r == CWS_WAIT && wait_done && seq_clk_on && s_last;
    wire cws_word_t progress_word = {6'h00, seq_step_pointer_r, 3'h0, running};
    wire cws_word_t rd_word =
        link.addr == `CWS_ENABLE_OFS ? {7'h00, seq_clock_enable_r, 3'h0, write_index_r} :
        link.addr == `CWS_PROG_OFS ? {1'b0, prog_r} :
        link.addr == `CWS_STEPDAT_OFS ? {1'b0, stepdat_r} :
        link.addr == `CWS_LAUNCH_OFS ? {7'h00, seq_launch_r, 2'h0, seq_first_step_r} :
        link.addr == `CWS_PROGRESS_OFS ? progress_word :
        link.addr == `CWS_IRQ_STATUS_OFS ? {15'h0000, seq_done_irq_flag_r} :
        host_ok ? ctrl_mem[link.addr] : 16'h0000;

    // ==========================================
    // step memory, RAM part written through the programming registers
    always_ff @(posedge ref_clk_in) begin
        if (host_wr && link.addr == `CWS_STEPDAT_OFS) begin
            // step word: last marker, wait code, data, then count/offset/addr
            step_mem[write_index_r] <= {link.wdata[14], link.wdata[11:8], link.wdata[7:0],
                prog_r[14:0]};
        end
    end

    // ==========================================
    // register file
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            seq_clock_enable_r <= 1'b0;
            write_index_r <= 5'h00;
            prog_r <= 15'h0000;
            stepdat_r <= 15'h0000;
            seq_first_step_r <= 6'h00;
            rdata_r <= 16'h0000;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= link.rd;
            rdata_r <= link.rd ? rd_word : 16'h0000;
            if (host_wr && link.addr == `CWS_ENABLE_OFS) begin
                seq_clock_enable_r <= link.wdata[`CWS_ENA_BIT];
                write_index_r <= link.wdata[4:0];
            end
            if (host_wr && link.addr == `CWS_PROG_OFS) prog_r <= link.wdata[14:0];
            if (host_wr && link.addr == `CWS_STEPDAT_OFS) stepdat_r <= link.wdata[14:0];
            if (wr_launch && !running) seq_first_step_r <= link.wdata[5:0];
        end
    end

    // control registers, written by host when idle or by the walk
    always_ff @(posedge ref_clk_in) begin
        if (state_r == CWS_APPLY && seq_clk_on) begin
            ctrl_mem[s_addr] <= (ctrl_mem[s_addr] & ~fmask) | fdata;
        end else if (host_wr && !is_seq_reg(link.addr)) begin
            ctrl_mem[link.addr] <= link.wdata;
        end
    end

    // ==========================================
    // walk
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state_r <= CWS_IDLE;
            seq_launch_r <= 1'b0;
            seq_step_pointer_r <= 6'h00;
            seq_done_irq_flag_r <= 1'b0;
            step_r <= 28'h0000000;
            wait_cnt_r <= 26'h0000000;
        end else begin
            if (seq_end) seq_done_irq_flag_r <= 1'b1;
            else if (host_wr && link.addr == `CWS_IRQ_STATUS_OFS &&
                link.wdata[`CWS_DONE_IRQ_BIT]) seq_done_irq_flag_r <= 1'b0;
            if (cancel_req) begin
                state_r <= CWS_IDLE;
                seq_launch_r <= 1'b0;
            end else begin
                case (state_r)
                    CWS_IDLE: begin
                        if (start_req) begin
                            state_r <= CWS_FETCH;
                            seq_launch_r <= 1'b1;
                            seq_step_pointer_r <= link.wdata[5:0];
                        end
                    end
                    CWS_FETCH: begin
                        if (seq_clk_on) begin
                            step_r <= step_mem[seq_step_pointer_r];
                            state_r <= CWS_APPLY;
                        end
                    end
                    CWS_APPLY: begin
                        if (seq_clk_on) begin
                            wait_cnt_r <= step_cyc - 26'h0000002;
                            state_r <= CWS_WAIT;
                        end
                    end
                    CWS_WAIT: begin
                        if (seq_clk_on) begin
                            if (!wait_done) wait_cnt_r <= wait_cnt_r - 26'h0000001;
                            else if (s_last) begin
                                state_r <= CWS_IDLE;
                                seq_launch_r <= 1'b0;
                            end else begin
                                seq_step_pointer_r <= seq_step_pointer_r + 6'h01;
                                state_r <= CWS_FETCH;
                            end
                        end
                    end
                    default: state_r <= CWS_IDLE;
                endcase
            end
        end
    end

    // ==========================================
    // outputs
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            link.irq <= 1'b0;
            seq_running_out <= 1'b0;
            seq_step_pointer_out <= 6'h00;
        end else begin
            link.irq <= seq_done_irq_flag_r;
            seq_running_out <= running;
            seq_step_pointer_out <= seq_step_pointer_r;
        end
    end
    assign link.rdata = rdata_r;
    assign link.rvalid = rvalid_r;
endmodule

// [rtl/cws_host.sv]
// host controller end: turns software commands into link register accesses
`include "cws_defs.svh"

module cws_host (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // software port
    input wire logic [3:0] sw_addr_in,
    input wire logic [15:0] sw_wdata_in,
    input wire logic sw_wr_in,
    input wire logic sw_rd_in,
    output logic [15:0] sw_rdata_out,
    output logic irq_out,
    // register link
    cws_link_if.host link
);
    import cws_pkg::*;

    // ==========================================
    // state
    cws_hstate_t state_r;
    cws_addr_t addr_r;
    cws_word_t wdata_r;
    cws_word_t rdata_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_en_r;
    logic dev_irq_q_r;
    cws_word_t sw_rdata_r;

    wire logic busy = (state_r != CWS_H_IDLE);
    wire logic go = sw_wr_in && sw_addr_in == `CWS_H_CMD_OFS && !busy;
    wire logic go_wr = go && sw_wdata_in[1:0] == `CWS_H_CMD_WRITE;
    wire logic go_rd = go && sw_wdata_in[1:0] == `CWS_H_CMD_READ;
    wire logic dev_irq_rise = link.irq && !dev_irq_q_r;
    wire logic ev_done = state_r == CWS_H_READ && link.rvalid;
    wire logic [1:0] ev = {ev_done, dev_irq_rise};
    wire logic [1:0] clr = (sw_wr_in && sw_addr_in == `CWS_H_IRQ_CLR_OFS) ?
        sw_wdata_in[1:0] : 2'h0;
    wire cws_word_t sw_rd_word =
        sw_addr_in == `CWS_H_STAT_OFS ? {15'h0000, busy} :
        sw_addr_in == `CWS_H_IRQ_STAT_OFS ? {14'h0000, irq_stat_r} :
        sw_addr_in == `CWS_H_IRQ_EN_OFS ? {14'h0000, irq_en_r} :
        sw_addr_in == `CWS_H_RDATA_OFS ? rdata_r :
        sw_addr_in == `CWS_H_ADDR_OFS ? {8'h00, addr_r} :
        sw_addr_in == `CWS_H_WDATA_OFS ? wdata_r : 16'h0000;

    // ==========================================
    // software registers
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            addr_r <= 8'h00;
            wdata_r <= 16'h0000;
            irq_en_r <= 2'h0;
            irq_stat_r <= 2'h0;
            dev_irq_q_r <= 1'b0;
            sw_rdata_r <= 16'h0000;
            irq_out <= 1'b0;
        end else begin
            if (sw_wr_in && sw_addr_in == `CWS_H_ADDR_OFS) addr_r <= sw_wdata_in[7:0];
            if (sw_wr_in && sw_addr_in == `CWS_H_WDATA_OFS) wdata_r <= sw_wdata_in;
            if (sw_wr_in && sw_addr_in == `CWS_H_IRQ_EN_OFS) irq_en_r <= sw_wdata_in[1:0];
            irq_stat_r <= (irq_stat_r & ~clr) | ev;
            dev_irq_q_r <= link.irq;
            sw_rdata_r <= sw_rd_in ? sw_rd_word : 16'h0000;
            irq_out <= |(((irq_stat_r & ~clr) | ev) & irq_en_r);
        end
    end

    // ==========================================
    // link sequencing
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state_r <= CWS_H_IDLE;
            link.wr <= 1'b0;
            link.rd <= 1'b0;
            link.addr <= 8'h00;
            link.wdata <= 16'h0000;
            rdata_r <= 16'h0000;
        end else begin
            link.wr <= 1'b0;
            link.rd <= 1'b0;
            case (state_r)
                CWS_H_IDLE: begin
                    if (go_wr || go_rd) begin
                        link.addr <= addr_r;
                        link.wdata <= wdata_r;
                        link.wr <= go_wr;
                        link.rd <= go_rd;
                        state_r <= go_wr ? CWS_H_WROTE : CWS_H_READ;
                    end
                end
                CWS_H_READ: begin
                    if (link.rvalid) begin
                        rdata_r <= link.rdata;
                        state_r <= CWS_H_IDLE;
                    end
                end
                CWS_H_WROTE: state_r <= CWS_H_IDLE;
                default: state_r <= CWS_H_IDLE;
            endcase
        end
    end
    assign sw_rdata_out = sw_rdata_r;
endmodule

// [tb/cws_link_chk.sv]
// assertions on the sequencer link and device status
`include "cws_defs.svh"
module cws_link_chk (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // watched signals
    input wire logic system_clock_enable_in,
    input wire logic wr,
    input wire logic rd,
    input wire cws_pkg::cws_addr_t addr,
    input wire cws_pkg::cws_word_t wdata,
    input wire logic rvalid,
    input wire logic irq,
    input wire logic seq_running_out,
    input wire logic [5:0] seq_step_pointer_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import cws_pkg::*;
    logic ena_r;
    logic cancel_r;
    logic [5:0] first_r;
    wire launch_hit = wr && addr == `CWS_LAUNCH_OFS && wdata[8] && !wdata[9];
    wire cancel_hit = wr && addr == `CWS_LAUNCH_OFS && wdata[9];
    wire go_ok = launch_hit && wdata[5:0] <= `CWS_ROM_TOP && !seq_running_out && ena_r
        && system_clock_enable_in;
    wire go_bad = launch_hit && wdata[5:0] > `CWS_ROM_TOP && !seq_running_out;
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            ena_r <= 1'b0;
            cancel_r <= 1'b0;
            first_r <= 6'h00;
        end else begin
            if (wr && addr == `CWS_ENABLE_OFS) ena_r <= wdata[8];
            if (cancel_hit) cancel_r <= 1'b1;
            else if (go_ok) cancel_r <= 1'b0;
            if (go_ok) first_r <= wdata[5:0];
        end
    end
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (sys_rst_in);
    sequence s_go;
        go_ok;
    endsequence
    sequence s_end;
        $fell(seq_running_out) && !cancel_r;
    endsequence
    AST_RVALID_ONE: assert property (rd |=> rvalid)
        else $error("read answer missing");
    AST_RVALID_CAUSE: assert property (rvalid |-> $past(rd))
        else $error("read answer without read");
    AST_LAUNCH_BUSY: assert property (s_go |-> ##2 seq_running_out)
        else $error("launch did not set running");
    AST_LAUNCH_INDEX: assert property (s_go |-> ##[1:3] seq_step_pointer_out == first_r)
        else $error("pointer not at first step");
    AST_RESERVED: assert property (go_bad |-> ##2 !seq_running_out)
        else $error("reserved index started a run");
    AST_CANCEL: assert property (cancel_hit && seq_running_out |-> ##[1:2] !seq_running_out)
        else $error("cancel did not stop the run");
    AST_FROZEN: assert property (!system_clock_enable_in && seq_running_out && !wr
        |=> seq_running_out && $stable(seq_step_pointer_out))
        else $error("walk moved with clock disabled");
    AST_ASCEND: assert property ($past(seq_running_out, 4) && seq_running_out
        && $changed(seq_step_pointer_out)
        |-> seq_step_pointer_out == $past(seq_step_pointer_out) + 6'd1)
        else $error("step order not ascending");
    AST_DONE_IRQ: assert property (s_end |-> ##[0:2] irq)
        else $error("no done flag at sequence end");
endmodule

// [tb/test_control_write_sequencer.sv]
// self-checking bench for the host and device pair of the sequencer
`include "cws_defs.svh"
module test_control_write_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    import cws_pkg::*;
    localparam int STEP = 9 * `CWS_UNIT_CYC;
    localparam int FRZ = 15000;
    logic ref_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic sce = 1'b1;
    logic [3:0] sw_addr = 4'h0;
    logic [15:0] sw_wdata = 16'h0000;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic [15:0] sw_rdata;
    logic irq_out;
    logic seq_running;
    logic [5:0] seq_ptr;
    logic rd_d = 1'b0;
    logic [31:0] expq[$];
    logic [31:0] note;
    int n_fail = 0;
    int total_checks = 0;
    int run_cyc = 0;
    logic [15:0] r0;
    logic [7:0] da;
    logic db;
    cws_link_if cws_link_if_inst ();
    cws_device cws_device_inst (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .system_clock_enable_in(sce), .link(cws_link_if_inst.dev),
        .seq_running_out(seq_running), .seq_step_pointer_out(seq_ptr));
    cws_host cws_host_inst (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .sw_addr_in(sw_addr), .sw_wdata_in(sw_wdata), .sw_wr_in(sw_wr), .sw_rd_in(sw_rd),
        .sw_rdata_out(sw_rdata), .irq_out(irq_out), .link(cws_link_if_inst.host));
    cws_link_chk cws_link_chk_inst (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .system_clock_enable_in(sce), .wr(cws_link_if_inst.wr), .rd(cws_link_if_inst.rd),
        .addr(cws_link_if_inst.addr), .wdata(cws_link_if_inst.wdata),
        .rvalid(cws_link_if_inst.rvalid), .irq(cws_link_if_inst.irq),
        .seq_running_out(seq_running), .seq_step_pointer_out(seq_ptr));
    always #20 ref_clk_in = ~ref_clk_in;
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m);
        total_checks++;
        if ((got & m) !== (exp & m)) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got & m, exp & m);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // read results checked against the oldest note
    always @(posedge ref_clk_in) begin
        if (rd_d) begin
            note = expq.pop_front();
            check(sw_rdata, note[31:16], note[15:0]);
        end
        rd_d <= sw_rd;
    end
    always @(posedge ref_clk_in) begin
        if (seq_running === 1'b1) run_cyc <= run_cyc + 1;
    end
    task automatic sw_wr_t(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk_in);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge ref_clk_in);
        sw_wr <= 1'b0;
    endtask
    task automatic sw_rd_t(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
        expq.push_back({e, m});
        @(posedge ref_clk_in);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge ref_clk_in);
        sw_rd <= 1'b0;
    endtask
    task automatic dev_wr(input logic [7:0] a, input logic [15:0] d);
        sw_wr_t(`CWS_H_ADDR_OFS, {8'h00, a});
        sw_wr_t(`CWS_H_WDATA_OFS, d);
        sw_wr_t(`CWS_H_CMD_OFS, {14'h0, `CWS_H_CMD_WRITE});
        repeat (3) @(posedge ref_clk_in);
    endtask
    task automatic dev_rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
        sw_wr_t(`CWS_H_ADDR_OFS, {8'h00, a});
        sw_wr_t(`CWS_H_CMD_OFS, {14'h0, `CWS_H_CMD_READ});
        repeat (4) @(posedge ref_clk_in);
        sw_rd_t(`CWS_H_RDATA_OFS, e, m);
    endtask
    task automatic wait_run(input logic lvl);
        int k = 0;
        while (seq_running !== lvl && k < 40000) begin
            @(posedge ref_clk_in);
            k++;
        end
        @(negedge ref_clk_in);
        check({15'h0, seq_running}, {15'h0, lvl}, 16'h0001);
    endtask
    initial begin
        repeat (80000) @(posedge ref_clk_in);
        n_fail++;
        wrap_up();
    end
    initial begin
        r0 = 16'($urandom(62889));
        repeat (20) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        dev_rd(`CWS_PROGRESS_OFS, 16'h0000, 16'h03f1);
        dev_rd(`CWS_ENABLE_OFS, 16'h0000, 16'h0100);
        dev_rd(`CWS_LAUNCH_OFS, 16'h0000, 16'h0300);
        $display("test reset values done");
        r0 = 16'($urandom());
        da = 8'($urandom());
        db = 1'($urandom());
        dev_wr(8'h10, r0);
        dev_wr(`CWS_ENABLE_OFS, 16'h0105);
        dev_wr(`CWS_PROG_OFS, 16'h2310);
        dev_wr(`CWS_STEPDAT_OFS, {8'h00, da});
        dev_wr(`CWS_ENABLE_OFS, 16'h0106);
        dev_wr(`CWS_PROG_OFS, 16'h0810);
        dev_wr(`CWS_STEPDAT_OFS, {8'h40, 7'h00, db});
        sw_wr_t(`CWS_H_IRQ_EN_OFS, 16'h0000);
        run_cyc = 0;
        dev_wr(`CWS_LAUNCH_OFS, 16'h0105);
        wait_run(1'b1);
        dev_rd(`CWS_PROGRESS_OFS, 16'h0051, 16'h03f1);
        dev_rd(8'h10, 16'h0000, 16'hffff);
        dev_wr(8'h10, ~r0);
        sce <= 1'b0;
        repeat (FRZ) @(posedge ref_clk_in);
        check({10'h0, seq_ptr}, 16'h0005, 16'h003f);
        sce <= 1'b1;
        repeat (STEP) @(posedge ref_clk_in);
        dev_rd(`CWS_PROGRESS_OFS, 16'h0061, 16'h03f1);
        wait_run(1'b0);
        check(16'(run_cyc - 2 * STEP - FRZ + 2) <= 16'h0004, 16'h0001, 16'h0001);
        dev_rd(8'h10, (r0 & 16'hfec7) | {7'h0, db, 2'h0, da[2:0], 3'h0}, 16'hffff);
        dev_rd(`CWS_PROGRESS_OFS, 16'h0060, 16'h03f1);
        dev_rd(`CWS_LAUNCH_OFS, 16'h0000, 16'h0100);
        check({15'h0, cws_link_if_inst.irq}, 16'h0001, 16'h0001);
        check({15'h0, irq_out}, 16'h0000, 16'h0001);
        sw_rd_t(`CWS_H_IRQ_STAT_OFS, 16'h0003, 16'h0003);
        sw_wr_t(`CWS_H_IRQ_EN_OFS, 16'h0001);
        repeat (3) @(negedge ref_clk_in);
        check({15'h0, irq_out}, 16'h0001, 16'h0001);
        dev_wr(`CWS_IRQ_STATUS_OFS, 16'h0001);
        sw_wr_t(`CWS_H_IRQ_CLR_OFS, 16'h0003);
        repeat (3) @(negedge ref_clk_in);
        check({14'h0, cws_link_if_inst.irq, irq_out}, 16'h0000, 16'h0003);
        $display("test full run done");
        dev_wr(`CWS_LAUNCH_OFS, 16'h0131);
        repeat (3) @(negedge ref_clk_in);
        check({15'h0, seq_running}, 16'h0000, 16'h0001);
        dev_wr(`CWS_LAUNCH_OFS, 16'h0105);
        wait_run(1'b1);
        dev_wr(`CWS_ENABLE_OFS, 16'h0006);
        repeat (STEP) @(posedge ref_clk_in);
        check({9'h000, seq_ptr, seq_running}, 16'h000b, 16'h007f);
        dev_wr(`CWS_LAUNCH_OFS, 16'h0200);
        check({15'h0, seq_running}, 16'h0000, 16'h0001);
        dev_rd(`CWS_LAUNCH_OFS, 16'h0000, 16'h0100);
        dev_wr(8'h10, ~r0);
        dev_rd(8'h10, ~r0, 16'hffff);
        sw_rd_t(`CWS_H_WDATA_OFS, ~r0, 16'hffff);
        sw_rd_t(`CWS_H_ADDR_OFS, 16'h0010, 16'h00ff);
        sw_rd_t(`CWS_H_STAT_OFS, 16'h0000, 16'h0001);
        $display("test reserved and cancel done");
        repeat (4) @(posedge ref_clk_in);
        wrap_up();
    end
endmodule
